/* File: hw/param_store_pkg.sv */
package param_store_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ENTRIES = 8;
  localparam int IDX_W = 3;
  localparam int VAL_W = 16;
  localparam int REG_AW = 8;
  localparam int FN_W = 10;
  localparam int FN_STATES = 8;
  localparam int TERMS = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] OFS_SELECT = 8'h00;
  localparam logic [REG_AW-1:0] OFS_DESC = 8'h04;
  localparam logic [REG_AW-1:0] OFS_EDIT = 8'h08;
  localparam logic [REG_AW-1:0] OFS_COMMAND = 8'h0C;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h10;
  localparam logic [REG_AW-1:0] OFS_SAVED = 8'h14;
  localparam logic [REG_AW-1:0] OFS_UNIT = 8'h18;
  localparam logic [REG_AW-1:0] OFS_COPY = 8'h1C;
  localparam logic [REG_AW-1:0] OFS_IN_ONE = 8'h20;
  localparam logic [REG_AW-1:0] OFS_IN_TWO = 8'h24;
  localparam logic [REG_AW-1:0] OFS_IN_THREE = 8'h28;
  localparam logic [REG_AW-1:0] OFS_OUT_ASSIGN = 8'h2C;
  localparam logic [REG_AW-1:0] OFS_DISPLAY = 8'h30;
  localparam logic [REG_AW-1:0] OFS_BUFFER = 8'h34;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DESC_NUM_LSB = 0;
  localparam int DESC_GRP_LSB = 8;
  localparam int DESC_CLS_LSB = 12;
  localparam int DESC_CPY_LSB = 16;
  localparam int CMD_COMMIT = 0;
  localparam int CMD_ABANDON = 1;
  localparam int CMD_COPY = 2;
  localparam int CMD_VERIFY = 3;
  localparam int ST_RUNNING = 0;
  localparam int ST_REJECTED = 1;
  localparam int ST_PENDING = 2;
  localparam int ST_COPY_DONE = 3;
  localparam int ST_VERIFY_BAD = 4;
  localparam int UNIT_SRC_CAP_LSB = 0;
  localparam int UNIT_SRC_VOLT_LSB = 8;
  localparam int UNIT_DST_CAP_LSB = 16;
  localparam int UNIT_DST_VOLT_LSB = 24;
  localparam int UNIT_FIELD_W = 8;
  localparam int COPY_MASK_LSB = 0;
  localparam int VERIFY_MASK_LSB = 8;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [6:0] CODE_NUMBER_MAX = 7'h63;
  localparam logic [VAL_W-1:0] VAL_RESET = 16'h0000;
  localparam logic [VAL_W-1:0] NEG_LOGIC_OFFSET = 16'h03E8;
  localparam logic [FN_W-1:0] FN_COAST_STOP = 10'h007;
  localparam logic [VAL_W-1:0] DISPLAY_LIMIT = 16'h270F;
  localparam logic [VAL_W-1:0] DIGIT_BASE = 16'h000A;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GRP_FUNDAMENTAL = 3'b000,
    GRP_EXT_TERMINAL = 3'b001,
    GRP_CONTROL = 3'b010,
    GRP_MOTOR_ONE = 3'b011,
    GRP_HIGH_PERF = 3'b100,
    GRP_MOTOR_TWO = 3'b101,
    GRP_APPLICATION = 3'b110,
    GRP_LINK = 3'b111
  } group_t;

  typedef enum logic [1:0] {
    CLS_IMMEDIATE = 2'b00,
    CLS_RUN_CHANGE = 2'b01,
    CLS_LOCKED = 2'b10
  } edit_class_t;

  typedef enum logic [1:0] {
    CPY_ALWAYS = 2'b00,
    CPY_CAPACITY = 2'b01,
    CPY_VOLTAGE = 2'b10,
    CPY_NEVER = 2'b11
  } copy_attr_t;

  typedef struct packed {
    group_t group;
    logic [6:0] number;
    edit_class_t cls;
    copy_attr_t copy;
  } param_desc_t;

  typedef struct packed {
    logic neg;
    logic [FN_W-1:0] fn;
  } term_assign_t;

endpackage

/* File: hw/parameter_store_and_polarity.sv */
`timescale 1ns/1ps
module parameter_store_and_polarity
  import param_store_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [DATA_W-1:0] hrdata,
  output logic [1:0] hresp,
  // drive state and terminals
  input wire logic motor_running,
  input wire logic digital_input_one,
  input wire logic digital_input_two,
  input wire logic digital_input_three,
  input wire logic [FN_STATES-1:0] function_state,
  output logic coast_stop_command,
  output logic transistor_output,
  // parameter value of selected entry
  output logic [VAL_W-1:0] param_value,
  output logic [VAL_W-1:0] display_value
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic term_assign_t decode_assign(input logic [VAL_W-1:0] v);
    term_assign_t r;
    r.neg = (v >= NEG_LOGIC_OFFSET);
    r.fn = FN_W'(v % NEG_LOGIC_OFFSET);
    return r;
  endfunction

  function automatic logic [VAL_W-1:0] leading_digits(input logic [VAL_W-1:0] v);
    return (v > DISPLAY_LIMIT) ? VAL_W'(v / DIGIT_BASE) : v;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic rd_pend;
  logic wr_pend;
  logic [REG_AW-1:0] rd_addr;
  logic [REG_AW-1:0] wr_addr;
  logic [DATA_W-1:0] read_word;
  logic [IDX_W-1:0] sel_idx;
  param_desc_t desc [ENTRIES];
  logic [VAL_W-1:0] active [ENTRIES];
  logic [VAL_W-1:0] saved [ENTRIES];
  logic [VAL_W-1:0] staged [ENTRIES];
  logic [VAL_W-1:0] buffer [ENTRIES];
  logic [ENTRIES-1:0] pending;
  logic [ENTRIES-1:0] copy_mask;
  logic [ENTRIES-1:0] verify_mask;
  logic rejected;
  logic copy_done;
  logic verify_bad;
  logic [DATA_W-1:0] unit_cfg;
  logic [VAL_W-1:0] input_one_assignment;
  logic [VAL_W-1:0] input_two_assignment;
  logic [VAL_W-1:0] input_three_assignment;
  logic [VAL_W-1:0] out_assignment;
  logic take;
  logic [VAL_W-1:0] wval;
  logic locked_now;
  logic cap_differs;
  logic volt_differs;
  param_desc_t wdesc;
  term_assign_t out_dec;
  term_assign_t in_dec [TERMS];
  logic [TERMS-1:0] in_pin;

  assign take = hsel && htrans[1] && hready;
  assign wval = hwdata[VAL_W-1:0];
  assign locked_now = (desc[sel_idx].cls == CLS_LOCKED) && motor_running;
  assign wdesc.number = hwdata[DESC_NUM_LSB +: 7];
  assign wdesc.group = group_t'(hwdata[DESC_GRP_LSB +: 3]);
  assign wdesc.cls = edit_class_t'(hwdata[DESC_CLS_LSB +: 2]);
  assign wdesc.copy = copy_attr_t'(hwdata[DESC_CPY_LSB +: 2]);
  assign cap_differs = unit_cfg[UNIT_SRC_CAP_LSB +: UNIT_FIELD_W]
                    != unit_cfg[UNIT_DST_CAP_LSB +: UNIT_FIELD_W];
  assign volt_differs = unit_cfg[UNIT_SRC_VOLT_LSB +: UNIT_FIELD_W]
                     != unit_cfg[UNIT_DST_VOLT_LSB +: UNIT_FIELD_W];
  assign out_dec = decode_assign(out_assignment);
  assign in_dec[0] = decode_assign(input_one_assignment);
  assign in_dec[1] = decode_assign(input_two_assignment);
  assign in_dec[2] = decode_assign(input_three_assignment);
  assign in_pin = {digital_input_three, digital_input_two, digital_input_one};

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      rd_addr <= '0;
      wr_addr <= '0;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= HRESP_OKAY;
    end else if (ce) begin
      hresp <= HRESP_OKAY;
      wr_pend <= take && hwrite;
      if (take) begin
        if (hwrite) begin
          wr_addr <= haddr[REG_AW-1:0];
        end else begin
          rd_addr <= haddr[REG_AW-1:0];
          rd_pend <= 1'b1;
          hreadyout <= 1'b0;
        end
      end else if (rd_pend) begin
        hrdata <= read_word;
        rd_pend <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  always_comb begin
    read_word = '0;
    case (rd_addr)
      OFS_SELECT: read_word[IDX_W-1:0] = sel_idx;
      OFS_DESC: begin
        read_word[DESC_NUM_LSB +: 7] = desc[sel_idx].number;
        read_word[DESC_GRP_LSB +: 3] = desc[sel_idx].group;
        read_word[DESC_CLS_LSB +: 2] = desc[sel_idx].cls;
        read_word[DESC_CPY_LSB +: 2] = desc[sel_idx].copy;
      end
      OFS_EDIT: read_word[VAL_W-1:0] = active[sel_idx];
      OFS_STATUS: begin
        read_word[ST_RUNNING] = motor_running;
        read_word[ST_REJECTED] = rejected;
        read_word[ST_PENDING] = pending[sel_idx];
        read_word[ST_COPY_DONE] = copy_done;
        read_word[ST_VERIFY_BAD] = verify_bad;
      end
      OFS_SAVED: read_word[VAL_W-1:0] = saved[sel_idx];
      OFS_UNIT: read_word = unit_cfg;
      OFS_COPY: begin
        read_word[COPY_MASK_LSB +: ENTRIES] = copy_mask;
        read_word[VERIFY_MASK_LSB +: ENTRIES] = verify_mask;
      end
      OFS_IN_ONE: read_word[VAL_W-1:0] = input_one_assignment;
      OFS_IN_TWO: read_word[VAL_W-1:0] = input_two_assignment;
      OFS_IN_THREE: read_word[VAL_W-1:0] = input_three_assignment;
      OFS_OUT_ASSIGN: read_word[VAL_W-1:0] = out_assignment;
      OFS_DISPLAY: read_word[VAL_W-1:0] = leading_digits(active[sel_idx]);
      OFS_BUFFER: read_word[VAL_W-1:0] = buffer[sel_idx];
      default: read_word = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_idx <= '0;
      unit_cfg <= '0;
      input_one_assignment <= VAL_RESET;
      input_two_assignment <= VAL_RESET;
      input_three_assignment <= VAL_RESET;
      out_assignment <= VAL_RESET;
      for (int i = 0; i < ENTRIES; i++) begin
        desc[i] <= '0;
      end
    end else if (ce && wr_pend) begin
      case (wr_addr)
        OFS_SELECT: sel_idx <= hwdata[IDX_W-1:0];
        OFS_DESC: begin
          if (wdesc.number <= CODE_NUMBER_MAX) begin
            desc[sel_idx] <= wdesc;
          end
        end
        OFS_UNIT: unit_cfg <= hwdata;
        OFS_IN_ONE: input_one_assignment <= wval;
        OFS_IN_TWO: input_two_assignment <= wval;
        OFS_IN_THREE: input_three_assignment <= wval;
        OFS_OUT_ASSIGN: out_assignment <= wval;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // edit, commit and abandon
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending <= '0;
      rejected <= 1'b0;
      for (int i = 0; i < ENTRIES; i++) begin
        active[i] <= VAL_RESET;
        saved[i] <= VAL_RESET;
        staged[i] <= VAL_RESET;
      end
    end else if (ce && wr_pend) begin
      if (wr_addr == OFS_STATUS && hwdata[ST_REJECTED]) begin
        rejected <= 1'b0;
      end
      if (wr_addr == OFS_DESC && wdesc.number > CODE_NUMBER_MAX) begin
        rejected <= 1'b1;
      end
      if (wr_addr == OFS_EDIT) begin
        if (locked_now) begin
          rejected <= 1'b1;
        end else if (desc[sel_idx].cls == CLS_IMMEDIATE) begin
          active[sel_idx] <= wval;
          pending[sel_idx] <= 1'b1;
        end else begin
          staged[sel_idx] <= wval;
          pending[sel_idx] <= 1'b1;
        end
      end
      if (wr_addr == OFS_COMMAND && hwdata[CMD_COMMIT] && pending[sel_idx]) begin
        if (locked_now) begin
          rejected <= 1'b1;
        end else if (desc[sel_idx].cls == CLS_IMMEDIATE) begin
          saved[sel_idx] <= active[sel_idx];
          pending[sel_idx] <= 1'b0;
        end else begin
          active[sel_idx] <= staged[sel_idx];
          saved[sel_idx] <= staged[sel_idx];
          pending[sel_idx] <= 1'b0;
        end
      end else if (wr_addr == OFS_COMMAND && hwdata[CMD_ABANDON] && pending[sel_idx]) begin
        if (desc[sel_idx].cls == CLS_IMMEDIATE) begin
          active[sel_idx] <= saved[sel_idx];
        end
        pending[sel_idx] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // copy and verify
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      copy_mask <= '0;
      verify_mask <= '0;
      copy_done <= 1'b0;
      verify_bad <= 1'b0;
      for (int i = 0; i < ENTRIES; i++) begin
        buffer[i] <= VAL_RESET;
      end
    end else if (ce && wr_pend) begin
      if (wr_addr == OFS_STATUS && hwdata[ST_COPY_DONE]) begin
        copy_done <= 1'b0;
      end
      if (wr_addr == OFS_COMMAND && hwdata[CMD_COPY]) begin
        copy_done <= 1'b1;
        for (int i = 0; i < ENTRIES; i++) begin
          unique case (desc[i].copy)
            CPY_ALWAYS: copy_mask[i] <= 1'b1;
            CPY_CAPACITY: copy_mask[i] <= !cap_differs;
            CPY_VOLTAGE: copy_mask[i] <= !volt_differs;
            CPY_NEVER: copy_mask[i] <= 1'b0;
          endcase
          if (desc[i].copy == CPY_ALWAYS
              || (desc[i].copy == CPY_CAPACITY && !cap_differs)
              || (desc[i].copy == CPY_VOLTAGE && !volt_differs)) begin
            buffer[i] <= saved[i];
          end
        end
      end else if (wr_addr == OFS_COMMAND && hwdata[CMD_VERIFY]) begin
        for (int i = 0; i < ENTRIES; i++) begin
          verify_mask[i] <= (desc[i].copy != CPY_NEVER) && (buffer[i] != saved[i]);
        end
        verify_bad <= 1'b0;
        for (int i = 0; i < ENTRIES; i++) begin
          if ((desc[i].copy != CPY_NEVER) && (buffer[i] != saved[i])) begin
            verify_bad <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // terminals
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coast_stop_command <= 1'b0;
      transistor_output <= 1'b0;
    end else if (ce) begin
      coast_stop_command <= 1'b0;
      for (int t = 0; t < TERMS; t++) begin
        if (in_dec[t].fn == FN_COAST_STOP && (in_pin[t] ^ in_dec[t].neg)) begin
          coast_stop_command <= 1'b1;
        end
      end
      if (out_dec.fn < FN_W'(FN_STATES)) begin
        transistor_output <= function_state[out_dec.fn[IDX_W-1:0]] ^ out_dec.neg;
      end else begin
        transistor_output <= out_dec.neg;
      end
    end
  end

  // ----------------------------------------------------------------
  // value and display
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      param_value <= VAL_RESET;
      display_value <= VAL_RESET;
    end else if (ce) begin
      param_value <= active[sel_idx];
      display_value <= leading_digits(active[sel_idx]);
    end
  end

endmodule

/* File: testbench/param_store_assertions.sv */
`timescale 1ns/1ps
module param_store_checker
  import param_store_pkg::*;
(
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  // terminals and values
  input wire logic digital_input_one,
  input wire logic digital_input_two,
  input wire logic digital_input_three,
  input wire logic [FN_STATES-1:0] function_state,
  input wire logic coast_stop_command,
  input wire logic transistor_output,
  input wire logic [VAL_W-1:0] param_value,
  input wire logic [VAL_W-1:0] display_value
);
  logic [VAL_W-1:0] asg [4];
  logic [VAL_W-1:0] out_asg;
  logic [2:0] pin;
  logic [1:0] wr_idx;
  logic wr_pend, live, taken, rd_taken, exp_coast, exp_out;
  assign taken = hsel && htrans[1] && hready;
  assign rd_taken = taken && !hwrite;
  assign out_asg = asg[3];
  assign pin = {digital_input_three, digital_input_two, digital_input_one};
  // ----------------------------------------
  // mirror of terminal assignment writes
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 2'h0;
      live <= 1'b0;
    end else begin
      wr_pend <= taken && hwrite && haddr[7:4] == 4'h2;
      wr_idx <= haddr[3:2];
      live <= 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asg <= '{default: '0};
    end else if (wr_pend) begin
      asg[wr_idx] <= hwdata[VAL_W-1:0];
    end
  end
  always_comb begin
    exp_coast = 1'b0;
    for (int i = 0; i < TERMS; i++) begin
      if (asg[i] % NEG_LOGIC_OFFSET == VAL_W'(FN_COAST_STOP)) begin
        exp_coast = exp_coast | (pin[i] ^ (asg[i] >= NEG_LOGIC_OFFSET));
      end
    end
    exp_out = out_asg >= NEG_LOGIC_OFFSET;
    if (out_asg % NEG_LOGIC_OFFSET < 16'h0008) begin
      exp_out = exp_out ^ function_state[3'(out_asg % NEG_LOGIC_OFFSET)];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd;
    rd_taken;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_rd |=> s_rd_answer;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    taken && hwrite |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_wait_cause;
    !hreadyout |-> $past(rd_taken);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("stray wait state");
  property p_okay;
    hresp == HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_coast;
    live && $past(ce) |-> coast_stop_command == $past(exp_coast);
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop wrong");
  property p_out;
    live && $past(ce) |-> transistor_output == $past(exp_out);
  endproperty
  a_out: assert property (p_out) else $error("output terminal wrong");
  property p_hold;
    live && !$past(ce) |-> $stable(coast_stop_command) && $stable(transistor_output)
      && $stable(param_value);
  endproperty
  a_hold: assert property (p_hold) else $error("frozen output moved");
  property p_out_wide;
    $past(ce) && $past(out_asg) % NEG_LOGIC_OFFSET >= 16'h0008 |->
      transistor_output == ($past(out_asg) >= NEG_LOGIC_OFFSET);
  endproperty
  a_out_wide: assert property (p_out_wide) else $error("wide selector wrong");
  property p_disp_full;
    param_value <= DISPLAY_LIMIT |-> display_value == param_value;
  endproperty
  a_disp_full: assert property (p_disp_full) else $error("short value display");
  property p_disp_cut;
    param_value > DISPLAY_LIMIT |-> display_value == param_value / DIGIT_BASE;
  endproperty
  a_disp_cut: assert property (p_disp_cut) else $error("long value display");
endmodule
bind parameter_store_and_polarity param_store_checker u_chk (.hclk, .hresetn, .ce, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .digital_input_one,
  .digital_input_two, .digital_input_three, .function_state, .coast_stop_command,
  .transistor_output, .param_value, .display_value);

/* File: testbench/host_model.sv */
`timescale 1ns/1ps
module host_model
  import param_store_pkg::*;
(
  // clock
  input wire logic hclk,
  // ahb-lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic [DATA_W-1:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single word transfer, released lines show a changed pattern
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module tb;
  import param_store_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic motor_running = 1'b0;
  logic ce = 1'b1;
  logic [TERMS-1:0] pins = '0;
  logic [FN_STATES-1:0] function_state = '0;
  logic hsel, hwrite, hreadyout, coast_stop_command, transistor_output;
  logic [31:0] haddr;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [DATA_W-1:0] hwdata, hrdata;
  logic [VAL_W-1:0] param_value, display_value;
  int bad_count = 0;
  int checks_done = 0;
  int act [ENTRIES] = '{default: 0};
  int sav [ENTRIES] = '{default: 0};
  int stg [ENTRIES] = '{default: 0};
  int cls [ENTRIES] = '{default: 0};
  int vals [6] = '{32'h7, 32'h3EF, 32'h7D7, 32'h3, 32'h3F1, 32'h1F4};
  int cur = 0;
  always #2.5 hclk = ~hclk;
  host_model u_host (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata);
  parameter_store_and_polarity u_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .motor_running,
    .digital_input_one(pins[0]), .digital_input_two(pins[1]), .digital_input_three(pins[2]),
    .function_state, .coast_stop_command, .transistor_output, .param_value, .display_value);
  // ----------------------------------------
  // bus tasks and reference model
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic expect_rd(input string n, input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] q;
    u_host.xfer(1'b0, a, $urandom, q);
    `CHK(n, e & m, q & m)
  endtask
  task automatic sel(input int i);
    cur = i;
    wr(OFS_SELECT, i);
  endtask
  task automatic set_desc(input int c, input int cp);
    int w;
    w = $urandom_range(99) | cur << DESC_GRP_LSB | c << DESC_CLS_LSB | cp << DESC_CPY_LSB;
    cls[cur] = c;
    wr(OFS_DESC, w);
    expect_rd("desc", OFS_DESC, w);
  endtask
  task automatic edit(input int v);
    wr(OFS_EDIT, v);
    if (cls[cur] == 2 && motor_running) return;
    if (cls[cur] == 0) act[cur] = v;
    else stg[cur] = v;
  endtask
  task automatic cmd(input int b);
    wr(OFS_COMMAND, b);
    if (b == 1 && cls[cur] == 0) sav[cur] = act[cur];
    if (b == 1 && cls[cur] != 0) act[cur] = stg[cur];
    if (b == 1 && cls[cur] != 0) sav[cur] = stg[cur];
    if (b == 2 && cls[cur] == 0) act[cur] = sav[cur];
  endtask
  task automatic chk_val();
    int d;
    expect_rd("active", OFS_EDIT, act[cur]);
    expect_rd("saved", OFS_SAVED, sav[cur]);
    d = act[cur] > DISPLAY_LIMIT ? act[cur] / DIGIT_BASE : act[cur];
    `CHK("param_value", VAL_W'(act[cur]), param_value)
    `CHK("display_value", VAL_W'(d), display_value)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    give_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    int k, fn, neg, mask;
    r = $urandom(32'hE59D);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    expect_rd("desc", OFS_DESC, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    expect_rd("unmapped", 8'h3C, 32'h0);
    wr(OFS_DESC, CODE_NUMBER_MAX + 1);
    expect_rd("rejected", OFS_STATUS, 32'h2, 32'h2);
    wr(OFS_STATUS, 32'h2);
    edit(32'h64);
    expect_rd("pending", OFS_STATUS, 32'h4, 32'h4);
    chk_val();
    cmd(2);
    chk_val();
    edit(32'h3039);
    cmd(1);
    chk_val();
    expect_rd("display", OFS_DISPLAY, 32'h4D2);
    for (int c = 1; c < 3; c++) begin
      sel(c);
      set_desc(c, 0);
      @(posedge hclk);
      motor_running <= 1'b1;
      edit(32'h4D);
      chk_val();
      expect_rd("status", OFS_STATUS, c == 2 ? 32'h3 : 32'h1, 32'h3);
      wr(OFS_STATUS, 32'h2);
      @(posedge hclk);
      motor_running <= 1'b0;
      edit(32'h4D);
      cmd(1);
      chk_val();
    end
    for (int i = 0; i < ENTRIES; i++) begin
      sel(i);
      set_desc(0, i % 4);
      edit(i * 17 + 1);
      cmd(1);
    end
    for (int c = 3; c >= 0; c--) begin
      r = $urandom;
      wr(OFS_UNIT, {r[15:8] ^ {7'h0, c[1]}, r[7:0] ^ {7'h0, c[0]}, r[15:0]});
      wr(OFS_COMMAND, 32'h4);
      mask = 0;
      for (int i = 0; i < ENTRIES; i++) begin
        if (i % 4 == 0 || (i % 4 == 1 && !c[0]) || (i % 4 == 2 && !c[1])) mask |= 1 << i;
      end
      expect_rd("copy_mask", OFS_COPY, mask, 32'hFF);
      expect_rd("copy_done", OFS_STATUS, 32'h8, 32'h8);
    end
    wr(OFS_STATUS, 32'h8);
    expect_rd("copy_clear", OFS_STATUS, 32'h0, 32'h8);
    expect_rd("buffer", OFS_BUFFER, 32'h0);
    for (int v = 0; v < 3; v++) begin
      sel(v == 2 ? 0 : 3);
      if (v > 0) edit(32'h55);
      if (v > 0) cmd(1);
      wr(OFS_COMMAND, 32'h8);
      expect_rd("verify", OFS_STATUS, v == 2 ? 32'h10 : 32'h0, 32'h10);
      expect_rd("verify_mask", OFS_COPY, v == 2 ? 32'h100 : 32'h0, 32'hFF00);
    end
    for (int t = 0; t < 6; t++) begin
      k = $urandom_range(2);
      fn = vals[t] % 1000;
      neg = vals[t] >= 1000;
      for (int j = 0; j < TERMS; j++) wr(8'(OFS_IN_ONE + 4 * j), j == k ? vals[t] : 0);
      wr(OFS_OUT_ASSIGN, vals[t]);
      repeat (4) begin
        @(posedge hclk);
        pins <= $urandom;
        function_state <= $urandom;
        @(posedge hclk);
        #1;
        `CHK("coast", 1'(fn == 7 && (pins[k] ^ neg)), coast_stop_command)
        `CHK("output", 1'(fn < 8 ? function_state[fn % 8] ^ neg : neg), transistor_output)
      end
      @(posedge hclk);
      ce <= 1'b0;
      pins <= ~pins;
      function_state <= ~function_state;
      repeat (2) @(posedge hclk);
      #1;
      `CHK("frozen coast", 1'(fn == 7 && (!pins[k] ^ neg)), coast_stop_command)
      `CHK("frozen output", 1'(fn < 8 ? !function_state[fn % 8] ^ neg : neg), transistor_output)
      @(posedge hclk);
      ce <= 1'b1;
    end
    give_verdict();
  end
endmodule
